// >>> hw/gpx_edge_sync.sv
// two-flop synchroniser with rising/falling edge detect per bit
// assumes inputs synchronous-ish to mclk_i; adds two cycles of latency
module gpx_edge_sync #(
  parameter int WIDTH = 5
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] raw_i,
  input wire logic [WIDTH-1:0] pol_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] edge_o
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] prev;
  wire [WIDTH-1:0] rise = sync & ~prev;
  wire [WIDTH-1:0] fall = ~sync & prev;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end else begin
      meta <= raw_i;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level_o = sync;
  // pol 0 selects rising edge, 1 falling
  assign edge_o = (rise & ~pol_i) | (fall & pol_i);
endmodule : gpx_edge_sync

// >>> hw/gpx_pin_ctrl.sv
// pin, nmi and external interrupt controller with wishbone registers
// assumes single clock mclk_i, synchronous active-high reset_i
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`include "gpx_regs.svh"
module gpx_pin_ctrl (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic nmi_i,
  input wire gpx_pkg::gpx_pins_t gp_pin_i,
  output gpx_pkg::gpx_pins_t gp_pin_o,
  output gpx_pkg::gpx_pins_t gp_pin_oe_o,
  output logic nmi_event_o,
  output logic irq_o,
  output logic eeprom_autoinit_strap_o,
  output logic bus_role_o,
  output logic bus_reset_in_o,
  output logic bus_clk_in_o,
  output logic bus_grant_in_o,
  output logic bus_init_dev_select_o,
  output logic bus_cmd_byte_en_3_in_o,
  input wire logic bus_irq_a_out_i,
  input wire logic bus_request_out_i,
  input wire logic bus_cmd_byte_en_3_i,
  input wire logic bus_cmd_byte_en_3_oe_i
);
  import gpx_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  gpx_pins_t dir;
  gpx_pins_t out_val;
  logic [9:0] cfg;
  logic [4:0] stat;
  logic [4:0] mask;
  logic strap;
  gpx_bus_state_t bus_state;
  gpx_bus_state_t next_bus_state;

  wire [3:0] irq_enable_bits = cfg[`GPX_CFG_IRQEN_LSB +: `GPX_NEXT];
  wire [3:0] ext_irq_edge_polarity = cfg[`GPX_CFG_POL_LSB +: `GPX_NEXT];
  wire shared_gp_en = cfg[`GPX_CFG_GPEN_BIT];
  wire shared_bus_en = cfg[`GPX_CFG_BUSEN_BIT] & ~shared_gp_en;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // word select shared by write strobes and readback
  function automatic logic adr_hit(
    input logic [4:2] adr,
    input logic [2:0] word
  );
    return adr == word;
  endfunction : adr_hit

  wire bus_req = wb_cyc_i & wb_stb_i & (bus_state == GPX_IDLE);
  wire wr_en = bus_req & wb_we_i;
  wire sel_dir = adr_hit(wb_adr_i, `GPX_ADR_DIR);
  wire sel_out = adr_hit(wb_adr_i, `GPX_ADR_OUT);
  wire sel_in = adr_hit(wb_adr_i, `GPX_ADR_IN);
  wire sel_cfg = adr_hit(wb_adr_i, `GPX_ADR_CFG);
  wire sel_stat = adr_hit(wb_adr_i, `GPX_ADR_STAT);
  wire sel_mask = adr_hit(wb_adr_i, `GPX_ADR_MASK);
  wire sel_strap = adr_hit(wb_adr_i, `GPX_ADR_STRAP);
  // read-only words take no write strobe
  wire wr_dir = wr_en & sel_dir;
  wire wr_out = wr_en & sel_out;
  wire wr_cfg = wr_en & sel_cfg;
  wire wr_stat = wr_en & sel_stat;
  wire wr_mask = wr_en & sel_mask;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  wire [31:0] dir_m = merge({16'h0000, dir}, wb_dat_i, wb_sel_i);
  wire [31:0] out_m = merge({16'h0000, out_val}, wb_dat_i, wb_sel_i);
  wire [31:0] cfg_m = merge({22'h0, cfg}, wb_dat_i, wb_sel_i);
  wire [31:0] mask_m = merge({27'h0, mask}, wb_dat_i, wb_sel_i);
  wire [4:0] stat_clr = (wb_sel_i[0] & wr_stat) ? wb_dat_i[4:0] : 5'h00;

  // ----------------------------------------------------------------
  // synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [4:0] sync_level;
  logic [4:0] sync_edge;
  gpx_edge_sync #(.WIDTH(5)) u_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .raw_i({nmi_i, gp_pin_i[`GPX_EXT_LSB +: `GPX_NEXT]}),
    .pol_i({1'b0, ext_irq_edge_polarity}),
    .level_o(sync_level),
    .edge_o(sync_edge)
  );

  wire nmi_rise = sync_edge[`GPX_STAT_NMI_BIT];
  wire [3:0] ext_evt = sync_edge[3:0] & irq_enable_bits;
  wire [4:0] evt = {nmi_rise, ext_evt};
  // set wins over clear
  wire [4:0] next_stat = (stat & ~stat_clr) | evt;

  // ----------------------------------------------------------------
  // pin direction and muxing
  // ----------------------------------------------------------------
  // bus role slices, bit 0 is pin 9
  wire [6:0] shared_bus_oe = {1'b0, 1'b0, bus_irq_a_out_i, 1'b0, 1'b1, bus_cmd_byte_en_3_oe_i, 1'b0}
                             & {7{shared_bus_en}};
  wire [6:0] shared_bus_out = {1'b0, 1'b0, bus_irq_a_out_i ? 1'b0 : 1'b1, 1'b0,
                               bus_request_out_i, bus_cmd_byte_en_3_i, 1'b0};

  genvar p;
  generate
    for (p = 0; p < `GPX_NPIN; p++) begin : g_pin
      logic pin_oe;
      logic pin_out;
      if (p >= `GPX_SHARED_LSB) begin : g_shared
        // no driver until configuration picks a role
        assign pin_oe = (dir[p] & shared_gp_en) | shared_bus_oe[p - `GPX_SHARED_LSB];
        assign pin_out = shared_bus_en ? shared_bus_out[p - `GPX_SHARED_LSB] : out_val[p];
      end else if (p >= `GPX_EXT_LSB && p < `GPX_EXT_LSB + `GPX_NEXT) begin : g_ext
        // interrupt inputs never drive their pin
        assign pin_oe = dir[p] & ~irq_enable_bits[p - `GPX_EXT_LSB];
        assign pin_out = out_val[p];
      end else begin : g_plain
        assign pin_oe = dir[p];
        assign pin_out = out_val[p];
      end
      assign gp_pin_oe_o[p] = pin_oe;
      assign gp_pin_o[p] = pin_out;
    end
  endgenerate

  // shared bus role inputs, held low while not selected
  assign bus_role_o = shared_bus_en;
  assign bus_reset_in_o = shared_bus_en & gp_pin_i[15];
  assign bus_clk_in_o = shared_bus_en & gp_pin_i[14];
  assign bus_grant_in_o = shared_bus_en & gp_pin_i[12];
  assign bus_cmd_byte_en_3_in_o = shared_bus_en & gp_pin_i[10];
  assign bus_init_dev_select_o = shared_bus_en & gp_pin_i[9];

  // ----------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------
  gpx_pins_t in_view;
  generate
    for (p = 0; p < `GPX_NPIN; p++) begin : g_in
      if (p >= `GPX_SHARED_LSB) begin : g_shared
        // shared pins read 0 unless in general-purpose role
        assign in_view[p] = gp_pin_i[p] & shared_gp_en;
      end else if (p >= `GPX_EXT_LSB && p < `GPX_EXT_LSB + `GPX_NEXT) begin : g_ext
        assign in_view[p] = sync_level[p - `GPX_EXT_LSB];
      end else begin : g_plain
        assign in_view[p] = gp_pin_i[p];
      end
    end
  endgenerate

  // one-hot word selects, so the views simply or together
  wire [31:0] rd_dir = sel_dir ? {16'h0, dir} : 32'h0;
  wire [31:0] rd_out = sel_out ? {16'h0, out_val} : 32'h0;
  wire [31:0] rd_in = sel_in ? {16'h0, in_view} : 32'h0;
  wire [31:0] rd_cfg = sel_cfg ? {22'h0, cfg} : 32'h0;
  wire [31:0] rd_stat = sel_stat ? {27'h0, stat} : 32'h0;
  wire [31:0] rd_mask = sel_mask ? {27'h0, mask} : 32'h0;
  wire [31:0] rd_strap = sel_strap ? {31'h0, strap} : 32'h0;
  wire [31:0] rd_mux = rd_dir | rd_out | rd_in | rd_cfg | rd_stat | rd_mask | rd_strap;

  // ----------------------------------------------------------------
  // sequential
  // ----------------------------------------------------------------
  // ack state: a request held through its ack is not taken twice
  always_comb begin
    next_bus_state = bus_state;
    unique case (bus_state)
      GPX_IDLE: begin
        if (bus_req) begin
          next_bus_state = GPX_ACK;
        end
      end
      GPX_ACK: begin
        next_bus_state = GPX_IDLE;
      end
      default: begin
        next_bus_state = GPX_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      bus_state <= GPX_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_mux : 32'h0;
      bus_state <= next_bus_state;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      dir <= `GPX_RST_DIR;
    end else if (wr_dir) begin
      dir <= dir_m[15:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      out_val <= 16'h0;
    end else if (wr_out) begin
      out_val <= out_m[15:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cfg <= `GPX_RST_CFG;
    end else if (wr_cfg) begin
      cfg <= cfg_m[9:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mask <= 5'h0;
    end else if (wr_mask) begin
      mask <= mask_m[4:0];
    end
  end

  // sticky events, an event in the clear cycle survives
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      stat <= 5'h0;
    end else begin
      stat <= next_stat;
    end
  end

  // strap caught while reset is held, frozen at release
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      strap <= gp_pin_i[`GPX_STRAP_PIN];
    end
  end

  // ----------------------------------------------------------------
  // event outputs
  // ----------------------------------------------------------------
  assign eeprom_autoinit_strap_o = strap;
  assign nmi_event_o = nmi_rise;
  assign irq_o = |(stat & mask);
endmodule : gpx_pin_ctrl

// >>> hw/gpx_pkg.sv
// types shared by the pin/interrupt block
// assumes gpx_regs.svh holds the numeric constants
package gpx_pkg;
  typedef logic [15:0] gpx_pins_t;
  typedef enum logic [1:0] {GPX_IDLE, GPX_ACK} gpx_bus_state_t;
endpackage : gpx_pkg

// >>> hw/gpx_regs.svh
// register offsets, field positions and reset values of the pin/interrupt block
// assumes word-addressed wishbone slave with byte address bits [4:2]
`ifndef GPX_REGS_SVH
`define GPX_REGS_SVH
`define GPX_ADR_DIR 3'h0
`define GPX_ADR_OUT 3'h1
`define GPX_ADR_IN 3'h2
`define GPX_ADR_CFG 3'h3
`define GPX_ADR_STAT 3'h4
`define GPX_ADR_MASK 3'h5
`define GPX_ADR_STRAP 3'h6
`define GPX_CFG_IRQEN_LSB 4
`define GPX_CFG_POL_LSB 0
`define GPX_CFG_GPEN_BIT 8
`define GPX_CFG_BUSEN_BIT 9
`define GPX_STAT_NMI_BIT 4
`define GPX_RST_DIR 16'h0000
`define GPX_RST_CFG 10'h000
`define GPX_NPIN 16
`define GPX_NEXT 4
`define GPX_EXT_LSB 4
`define GPX_STRAP_PIN 3
`define GPX_SHARED_LSB 9
`endif

// >>> tb/gpx_partner.sv
// board side: interrupt sources and strap resistor
// assumes src_i is the board drive, oe_i high where the block drives
module gpx_partner (
  input wire gpx_pkg::gpx_pins_t src_i,
  input wire gpx_pkg::gpx_pins_t out_i,
  input wire gpx_pkg::gpx_pins_t oe_i,
  output gpx_pkg::gpx_pins_t pin_o
);
  timeunit 1ns / 1ps;
  // ---
  // wire level from both drivers
  // ---
  assign pin_o = (oe_i & out_i) | (~oe_i & src_i);
endmodule : gpx_partner

// >>> tb/gpx_pin_ctrl_bench.sv
// self-checking bench of the pin block
// assumes the partner resolves pin levels from board drive and block enables
module gpx_pin_ctrl_bench;
  timeunit 1ns / 1ps;
  logic mclk_i = 0, reset_i = 1, cyc = 0, we = 0, nmi = 0, ack, nev, irq, role;
  logic [4:2] adr = 0;
  logic [3:0] pol;
  logic [31:0] wdat = 0, dat, lf = 32'h24F7176E;
  logic [63:0] exq[$];
  gpx_pkg::gpx_pins_t src, pin, pout, poe;
  int num_errors = 0, check_count = 0, nev_cnt = 0;
  gpx_partner u_brd (.src_i(src), .out_i(pout), .oe_i(poe), .pin_o(pin));
  gpx_pin_ctrl u_dut (.mclk_i, .reset_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack), .nmi_i(nmi), .gp_pin_i(pin),
    .gp_pin_o(pout), .gp_pin_oe_o(poe), .nmi_event_o(nev), .irq_o(irq), .eeprom_autoinit_strap_o(),
    .bus_role_o(role), .bus_reset_in_o(), .bus_clk_in_o(), .bus_grant_in_o(), .bus_init_dev_select_o(),
    .bus_cmd_byte_en_3_in_o(), .bus_irq_a_out_i(lf[3]), .bus_request_out_i(lf[9]),
    .bus_cmd_byte_en_3_i(lf[5]), .bus_cmd_byte_en_3_oe_i(lf[7]));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic chk(input logic [31:0] got, exp, msk);
    check_count++;
    if ((got & msk) !== (exp & msk)) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // read data is noted here, compared by the ack watcher
  task automatic wb(input logic w, input logic [4:2] a, input logic [31:0] d, msk);
    exq.push_back({msk, d});
    cyc <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge mclk_i); while (ack !== 1'b1);
    cyc <= 0;
    @(posedge mclk_i);
  endtask : wb
  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) lf <= nxt(lf);
  always @(posedge mclk_i) if (nev === 1'b1) nev_cnt <= nev_cnt + 1;
  always @(posedge mclk_i) if (ack === 1'b1) begin
    chk(dat, exq[0][31:0], exq[0][63:32]);
    void'(exq.pop_front());
  end
  initial begin
    #20us;
    num_errors++;
    tally_and_finish();
  end
  // ---
  // stimulus
  // ---
  initial begin
    src = lf[31:16];
    repeat (8) @(posedge mclk_i);
    reset_i <= 0;
    @(posedge mclk_i);
    wb(0, 3'h6, {31'h0, src[3]}, 1);
    wb(0, 3'h7, 0, 32'hFFFFFFFF);
    wb(0, 3'h2, src & 16'h00F0, 32'hFEF0);
    pol = lf[3:0];
    src[7:4] <= pol;
    wb(1, 3'h3, {24'h0, 4'hF, pol}, 0);
    wb(1, 3'h5, 32'h1F, 0);
    repeat (6) @(posedge mclk_i);
    wb(1, 3'h4, 32'h1F, 0);
    for (int i = 0; i < 4; i++) begin
      src[4+i] <= ~pol[i];
      repeat (6) @(posedge mclk_i);
      wb(0, 3'h4, 1 << i, 32'h1F);
      chk(irq, 1, 1);
      wb(1, 3'h4, 1 << i, 0);
      src[4+i] <= pol[i];
      repeat (6) @(posedge mclk_i);
      wb(0, 3'h4, 0, 32'h1F);
      chk(irq, 0, 1);
    end
    wb(1, 3'h5, 32'h0F, 0);
    nmi <= 1;
    repeat (12) @(posedge mclk_i);
    chk(irq, 0, 1);
    chk(nev_cnt, 1, 32'hFFFFFFFF);
    wb(0, 3'h4, 32'h10, 32'h1F);
    nmi <= 0;
    wb(1, 3'h3, 32'h200, 0);
    repeat (20) @(posedge mclk_i) src[15:9] <= lf[22:16];
    chk(role, 1, 1);
    wb(0, 3'h2, 0, 32'hFE00);
    reset_i <= 1;
    src[3] <= 1;
    repeat (8) @(posedge mclk_i);
    reset_i <= 0;
    @(posedge mclk_i);
    wb(0, 3'h6, 1, 1);
    wb(0, 3'h3, 0, 32'h3FF);
    tally_and_finish();
  end
endmodule : gpx_pin_ctrl_bench

// >>> tb/gpx_pin_ctrl_sva.sv
// port checks of the pin block
// assumes a bind into gpx_pin_ctrl
module gpx_pin_ctrl_sva (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic nmi_i,
  input wire gpx_pkg::gpx_pins_t gp_pin_i,
  input wire gpx_pkg::gpx_pins_t gp_pin_o,
  input wire gpx_pkg::gpx_pins_t gp_pin_oe_o,
  input wire logic nmi_event_o,
  input wire logic eeprom_autoinit_strap_o,
  input wire logic bus_role_o,
  input wire logic bus_reset_in_o,
  input wire logic bus_irq_a_out_i,
  input wire logic bus_request_out_i
);
  timeunit 1ns / 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // ---
  // properties
  // ---
  ack_answer_a: assert property (wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  nmi_edge_a: assert property (nmi_event_o |-> $past(nmi_i, 2) && !$past(nmi_i, 3))
    else $error("nmi without edge");
  nmi_once_a: assert property (nmi_event_o |=> !nmi_event_o [*4]) else $error("nmi twice");
  reset_oe_a: assert property ($fell(reset_i) |-> gp_pin_oe_o == 16'h0000) else $error("pin driven");
  shared_off_a: assert property (!bus_role_o |-> !bus_reset_in_o) else $error("shared pin live");
  irq_pin_a: assert property (bus_role_o |-> gp_pin_oe_o[13] == bus_irq_a_out_i) else $error("irq pin");
  bus_req_a: assert property (bus_role_o |-> gp_pin_oe_o[11] && gp_pin_o[11] == bus_request_out_i)
    else $error("request pin");
  strap_take_a: assert property ($fell(reset_i) |-> eeprom_autoinit_strap_o == $past(gp_pin_i[3]))
    else $error("strap value");
endmodule : gpx_pin_ctrl_sva
bind gpx_pin_ctrl gpx_pin_ctrl_sva u_sva (.mclk_i, .reset_i, .wb_stb_i, .wb_ack_o, .nmi_i, .gp_pin_i, .gp_pin_o,
  .gp_pin_oe_o, .nmi_event_o, .eeprom_autoinit_strap_o, .bus_role_o, .bus_reset_in_o, .bus_irq_a_out_i,
  .bus_request_out_i);
